// ### src/sbl_core.sv
// Contract
// - Async link is 8 data, no parity, 1 stop
// - Two 0x55 bytes measure and set baud
// - Send 0xCC after successful baud detection
// - First used interface locks out other
// - Clocked port idle-high clock, sample phase 1
// - Packet: length, checksum, length-2 data bytes
// - Checksum is byte sum of data only
// - Reply 0xCC good, 0x33 bad packet
// - Device may lead with zeros, then gapless
// - Device skips zeros before host reply
// - Bytes may arrive singly or in bursts
// - First data byte is the command code
// - Ping sets status success and acknowledges
// - Status query returns one-byte status packet
`timescale 1ns/100ps
`default_nettype none
module sbl_core #(
  parameter int DEPTH = 16,
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_i,
  // Asynchronous serial pins
  input  wire logic                     uart_rx_i,
  output logic                          uart_tx_o,
  // Clocked serial pins
  input  wire logic                     spi_sclk_i,
  input  wire logic                     spi_cs_n_i,
  input  wire logic                     spi_mosi_i,
  output logic                          spi_miso_o,
  output logic                          spi_miso_oe_n_o,
  // Command hand-off
  output var  sbl_pkg::sbl_cmd_t        cmd_o,
  output var  logic                     cmd_valid_o,
  input  wire logic [$clog2(DEPTH)-1:0] param_idx_i,
  output logic [7:0]                    param_o,
  // Global status
  input  wire logic                     status_we_i,
  input  wire logic [7:0]               status_i,
  output logic [7:0]                    status_o,
  output logic                          lock_uart_o,
  output logic                          lock_spi_o
);
  import sbl_pkg::*;

  localparam int IW = $clog2(DEPTH) + 1;
  localparam logic [IW-1:0] DEPTH_I = IW'(DEPTH);

  typedef enum {M_LEN, M_SUM, M_DATA, M_REPLY, M_EXEC,
                M_TLEN, M_TSUM, M_TDAT, M_WAIT} sbl_mstate_t;

  sbl_byte_t   u_rx;
  sbl_byte_t   s_rx;
  sbl_byte_t   u_tx;
  sbl_byte_t   s_tx;
  sbl_byte_t   rx;
  sbl_byte_t   tx;
  sbl_byte_t   fsm_tx;
  logic        u_rdy;
  logic        s_rdy;
  logic        tx_rdy;
  logic        tx_fire;
  logic        sync_done;
  sbl_lock_t   lock_q;
  logic        sync_pend_q;
  sbl_mstate_t st_q;
  logic [7:0]  len_q;
  logic [7:0]  sum_q;
  logic [7:0]  acc_q;
  logic [7:0]  left_q;
  logic [IW-1:0] idx_q;
  logic        ok_q;
  logic [7:0]  buf_q [DEPTH];
  logic [7:0]  status_q;
  logic        rx_nz;

  // -------------------------------------
  // Port engines
  // -------------------------------------
  sbl_uart #(
    .DIV_W (DIV_W)
  ) u_uart (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .enable_i    (lock_q != SBL_LOCK_SPI),
    .sync_done_o (sync_done),
    .rx_i        (uart_rx_i),
    .tx_o        (uart_tx_o),
    .rx_o        (u_rx),
    .tx_i        (u_tx),
    .tx_ready_o  (u_rdy)
  );

  sbl_spi u_spi (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .enable_i    (lock_q != SBL_LOCK_UART),
    .sclk_i      (spi_sclk_i),
    .cs_n_i      (spi_cs_n_i),
    .mosi_i      (spi_mosi_i),
    .miso_o      (spi_miso_o),
    .miso_oe_n_o (spi_miso_oe_n_o),
    .rx_o        (s_rx),
    .tx_i        (s_tx),
    .tx_ready_o  (s_rdy)
  );

  // -------------------------------------
  // Interface lock
  // -------------------------------------
  // Sticky until reset; a tie goes to the async port
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      lock_q <= SBL_LOCK_NONE;
    else if (lock_q == SBL_LOCK_NONE)
    begin
      if (sync_done)
        lock_q <= SBL_LOCK_UART;
      else if (s_rx.valid)
        lock_q <= SBL_LOCK_SPI;
    end
  end

  assign lock_uart_o = (lock_q == SBL_LOCK_UART);
  assign lock_spi_o  = (lock_q == SBL_LOCK_SPI);

  // Receive mux; locked-out port never reaches the parser
  always_comb
  begin
    rx = '0;
    if (lock_q == SBL_LOCK_UART)
      rx = u_rx;
    else if (lock_q == SBL_LOCK_SPI || !sync_done)
      rx = s_rx;
  end

  assign rx_nz = rx.valid && (rx.data != 8'h_00);

  // -------------------------------------
  // Transmit mux
  // -------------------------------------
  // Sync answer outranks packet traffic
  assign tx      = sync_pend_q ? sbl_byte_t'{valid: 1'b1, data: SBL_ACK} : fsm_tx;
  assign tx_rdy  = lock_uart_o ? u_rdy : (lock_spi_o & s_rdy);
  assign tx_fire = fsm_tx.valid & tx_rdy & ~sync_pend_q;
  assign u_tx    = lock_uart_o ? tx : '0;
  assign s_tx    = lock_spi_o ? tx : '0;

  // Pending sync answer; a new sync wins over the send
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      sync_pend_q <= 1'b0;
    else if (sync_done)
      sync_pend_q <= 1'b1;
    else if (lock_uart_o && u_rdy)
      sync_pend_q <= 1'b0;
  end

  // Byte offered by the packet engine in each sending state
  always_comb
  begin
    fsm_tx = '0;
    case (st_q)
      M_REPLY: fsm_tx = '{valid: 1'b1, data: ok_q ? SBL_ACK : SBL_NAK};
      M_TLEN:  fsm_tx = '{valid: 1'b1, data: SBL_STAT_LEN};
      M_TSUM:  fsm_tx = '{valid: 1'b1, data: status_q};
      M_TDAT:  fsm_tx = '{valid: 1'b1, data: status_q};
      default: fsm_tx = '0;
    endcase
  end

  // -------------------------------------
  // Packet engine
  // -------------------------------------
  // Byte-at-a-time parse, so bursts and single bytes look alike
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      st_q   <= M_LEN;
      len_q  <= '0;
      sum_q  <= '0;
      acc_q  <= '0;
      left_q <= '0;
      idx_q  <= '0;
      ok_q   <= 1'b0;
    end
    else
    begin
      case (st_q)
        M_LEN:
          if (rx_nz)
          begin
            len_q <= rx.data;
            if (rx.data < SBL_LEN_MIN)
            begin
              ok_q <= 1'b0;
              st_q <= M_REPLY;
            end
            else
              st_q <= M_SUM;
          end
        M_SUM:
          if (rx.valid)
          begin
            sum_q  <= rx.data;
            acc_q  <= '0;
            idx_q  <= '0;
            left_q <= len_q - SBL_LEN_MIN;
            if (len_q == SBL_LEN_MIN)
            begin
              ok_q <= (rx.data == 8'h_00);
              st_q <= M_REPLY;
            end
            else
              st_q <= M_DATA;
          end
        M_DATA:
          if (rx.valid)
          begin
            acc_q  <= acc_q + rx.data;
            left_q <= left_q - 1'b1;
            if (idx_q < DEPTH_I)
              idx_q <= idx_q + 1'b1;
            if (left_q == 8'h_01)
            begin
              ok_q <= ((acc_q + rx.data) == sum_q);
              st_q <= M_REPLY;
            end
          end
        M_REPLY:
          if (tx_fire)
            st_q <= (ok_q && len_q > SBL_LEN_MIN) ? M_EXEC : M_LEN;
        M_EXEC:
          // A query answers with a packet of its own
          st_q <= (buf_q[0] == SBL_CMD_STAT) ? M_TLEN : M_LEN;
        M_TLEN:
          if (tx_fire)
            st_q <= M_TSUM;
        M_TSUM:
          if (tx_fire)
            st_q <= M_TDAT;
        M_TDAT:
          if (tx_fire)
            st_q <= M_WAIT;
        M_WAIT:
          // Either answer ends the exchange; host resends on a NAK
          if (rx_nz)
            st_q <= M_LEN;
        default:
          st_q <= M_LEN;
      endcase
    end
  end

  // Data capture; overflow bytes still count toward the sum
  always_ff @(posedge sys_clk_i)
  begin
    if (st_q == M_DATA && rx.valid && idx_q < DEPTH_I)
      buf_q[idx_q[IW-2:0]] <= rx.data;
  end

  assign param_o = buf_q[param_idx_i];

  // -------------------------------------
  // Command dispatch
  // -------------------------------------
  // Ping and query stay inside; others go to the consumer
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      cmd_o       <= '0;
      cmd_valid_o <= 1'b0;
    end
    else
    begin
      cmd_valid_o <= 1'b0;
      if (st_q == M_EXEC && buf_q[0] != SBL_CMD_PING && buf_q[0] != SBL_CMD_STAT)
      begin
        cmd_o.code  <= buf_q[0];
        cmd_o.count <= len_q - SBL_STAT_LEN;
        cmd_valid_o <= 1'b1;
      end
    end
  end

  // Global status; ping outranks a consumer write
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      status_q <= SBL_ST_RST;
    else if (st_q == M_EXEC && buf_q[0] == SBL_CMD_PING)
      status_q <= SBL_ST_SUCCESS;
    else if (status_we_i)
      status_q <= status_i;
  end

  assign status_o = status_q;

endmodule
`default_nettype wire

// ### src/sbl_pkg.sv
`default_nettype none
package sbl_pkg;

  // ----------------------------------------
  // Protocol byte values
  // ----------------------------------------
  localparam logic [7:0] SBL_ACK      = 8'h_CC;
  localparam logic [7:0] SBL_NAK      = 8'h_33;
  localparam logic [7:0] SBL_SYNC     = 8'h_55;
  localparam logic [7:0] SBL_CMD_PING = 8'h_20;
  localparam logic [7:0] SBL_CMD_STAT = 8'h_23;

  // ----------------------------------------
  // Packet framing
  // ----------------------------------------
  localparam logic [7:0] SBL_LEN_MIN  = 8'h_02;  // Length and sum bytes only
  localparam logic [7:0] SBL_STAT_LEN = 8'h_03;  // Status reply packet length

  // ----------------------------------------
  // Status codes and reset values
  // ----------------------------------------
  localparam logic [7:0] SBL_ST_SUCCESS = 8'h_40;
  localparam logic [7:0] SBL_ST_RST     = 8'h_00;

  // ----------------------------------------
  // Auto-baud measurement
  // ----------------------------------------
  localparam logic [2:0] SBL_SYNC_FALLS = 3'h_4;  // Falls after the start edge
  localparam int         SBL_SYNC_SHIFT = 3;      // Those falls span 8 bit times
  localparam logic [3:0] SBL_UART_BITS  = 4'h_A;  // Start, 8 data, 1 stop
  localparam logic [2:0] SBL_SPI_LAST   = 3'h_7;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sbl_byte_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] count;
  } sbl_cmd_t;

  typedef enum {SBL_LOCK_NONE, SBL_LOCK_UART, SBL_LOCK_SPI} sbl_lock_t;

endpackage
`default_nettype wire

// ### src/sbl_uart.sv
`timescale 1ns/100ps
`default_nettype none
module sbl_uart #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // Control
  input  wire logic              enable_i,
  output var  logic              sync_done_o,
  // Pins
  input  wire logic              rx_i,
  output var  logic              tx_o,
  // Byte streams
  output var  sbl_pkg::sbl_byte_t rx_o,
  input  wire sbl_pkg::sbl_byte_t tx_i,
  output logic                   tx_ready_o
);
  import sbl_pkg::*;

  typedef enum {U_HUNT, U_MEAS, U_WAITHI, U_IDLE, U_RX} sbl_ustate_t;

  logic [2:0]       rx_s_q;
  logic             lvl_q;
  logic             lvl_d;
  logic             fall;
  sbl_ustate_t      st_q;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] tmr_q;
  logic [2:0]       fcnt_q;
  logic [3:0]       bit_q;
  logic [7:0]       sh_q;
  logic             synced_q;
  logic [9:0]       tx_sh_q;
  logic [3:0]       tx_bit_q;
  logic [DIV_W-1:0] tx_tmr_q;

  // Three-stage sync; level moves only when stages two and three agree
  assign lvl_d = (rx_s_q[1] == rx_s_q[2]) ? rx_s_q[2] : lvl_q;
  assign fall  = lvl_q & ~lvl_d;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rx_s_q <= 3'h_7;
      lvl_q  <= 1'b1;
    end
    else
    begin
      rx_s_q <= {rx_s_q[1:0], rx_i};
      lvl_q  <= lvl_d;
    end
  end

  // -------------------------------------
  // Auto-baud and receiver
  // -------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    rx_o        <= '0;
    sync_done_o <= 1'b0;
    if (reset_i || !enable_i)
    begin
      st_q     <= U_HUNT;
      synced_q <= 1'b0;
      div_q    <= '1;
      cnt_q    <= '0;
      tmr_q    <= '0;
      fcnt_q   <= '0;
      bit_q    <= '0;
      sh_q     <= '0;
    end
    else
    begin
      case (st_q)
        U_HUNT:
          if (fall)
          begin
            st_q   <= U_MEAS;
            cnt_q  <= '0;
            fcnt_q <= '0;
          end
        U_MEAS:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (fall)
          begin
            fcnt_q <= fcnt_q + 1'b1;
            if (fcnt_q == SBL_SYNC_FALLS - 1'b1)
            begin
              div_q <= (cnt_q + 1'b1) >> SBL_SYNC_SHIFT;
              st_q  <= U_WAITHI;
            end
          end
        end
        U_WAITHI:
          if (lvl_q)
            st_q <= U_IDLE;
        U_IDLE:
          if (fall)
          begin
            st_q  <= U_RX;
            tmr_q <= div_q >> 1;  // Sample mid-bit
            bit_q <= '0;
          end
        U_RX:
          if (tmr_q == '0)
          begin
            tmr_q <= div_q - 1'b1;
            bit_q <= bit_q + 1'b1;
            if (bit_q == '0 && lvl_q)
              st_q <= U_IDLE;  // Glitch, not a start bit
            else if (bit_q == SBL_UART_BITS - 1'b1)
            begin
              // 8N1: framing errors drop the byte
              st_q <= U_IDLE;
              if (!synced_q)
              begin
                if (sh_q == SBL_SYNC && lvl_q)
                begin
                  synced_q    <= 1'b1;
                  sync_done_o <= 1'b1;
                end
                else
                  st_q <= U_HUNT;  // Re-measure on host retry
              end
              else if (lvl_q)
                rx_o <= '{valid: 1'b1, data: sh_q};
            end
            else if (bit_q != '0)
              sh_q <= {lvl_q, sh_q[7:1]};
          end
          else
            tmr_q <= tmr_q - 1'b1;
        default:
          st_q <= U_HUNT;
      endcase
    end
  end

  // -------------------------------------
  // Transmitter, 8N1 at the measured rate
  // -------------------------------------
  assign tx_ready_o = enable_i & synced_q & (tx_bit_q == '0);
  assign tx_o       = tx_sh_q[0];

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      tx_sh_q  <= '1;
      tx_bit_q <= '0;
      tx_tmr_q <= '0;
    end
    else if (tx_i.valid && tx_ready_o)
    begin
      tx_sh_q  <= {1'b1, tx_i.data, 1'b0};
      tx_bit_q <= SBL_UART_BITS;
      tx_tmr_q <= div_q - 1'b1;
    end
    else if (tx_bit_q != '0)
    begin
      if (tx_tmr_q == '0)
      begin
        tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q - 1'b1;
        tx_tmr_q <= div_q - 1'b1;
      end
      else
        tx_tmr_q <= tx_tmr_q - 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### src/sbl_spi.sv
`timescale 1ns/100ps
`default_nettype none
module sbl_spi (
  // Clock, reset and enable
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  input  wire logic               enable_i,
  // Pins
  input  wire logic               sclk_i,
  input  wire logic               cs_n_i,
  input  wire logic               mosi_i,
  output var  logic               miso_o,
  output var  logic               miso_oe_n_o,
  // Byte streams
  output var  sbl_pkg::sbl_byte_t rx_o,
  input  wire sbl_pkg::sbl_byte_t tx_i,
  output logic                    tx_ready_o
);
  import sbl_pkg::*;

  logic [2:0] s0_q;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] lvl_q;
  logic [2:0] lvl_d;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_start;
  logic [2:0] bit_q;
  logic [7:0] rsh_q;
  logic [7:0] tsh_q;
  logic [7:0] next_tx;

  // Three-stage sync per pin: {sclk, cs_n, mosi}
  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    assign lvl_d[i] = (s1_q[i] == s2_q[i]) ? s2_q[i] : lvl_q[i];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      s0_q  <= 3'h_6;
      s1_q  <= 3'h_6;
      s2_q  <= 3'h_6;
      lvl_q <= 3'h_6;
    end
    else
    begin
      s0_q  <= {sclk_i, cs_n_i, mosi_i};
      s1_q  <= s0_q;
      s2_q  <= s1_q;
      lvl_q <= lvl_d;
    end
  end

  // Mode with idle-high clock, sample on rise, shift on fall
  assign cs_start = enable_i & lvl_q[1] & ~lvl_d[1];
  assign sck_rise = enable_i & ~lvl_d[1] & ~lvl_q[2] & lvl_d[2];
  assign sck_fall = enable_i & ~lvl_d[1] & lvl_q[2] & ~lvl_d[2];

  // Zero filler when nothing queued keeps host clocking harmless
  assign next_tx    = tx_i.valid ? tx_i.data : 8'h_00;
  assign tx_ready_o = cs_start | (sck_rise & (bit_q == SBL_SPI_LAST));

  // -------------------------------------
  // Shift registers, MSB first
  // -------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    rx_o <= '0;
    if (reset_i || !enable_i)
    begin
      bit_q       <= '0;
      rsh_q       <= '0;
      tsh_q       <= '0;
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end
    else if (lvl_d[1])
    begin
      bit_q       <= '0;
      miso_oe_n_o <= 1'b1;
    end
    else
    begin
      miso_oe_n_o <= 1'b0;
      if (cs_start)
      begin
        tsh_q  <= next_tx;
        miso_o <= next_tx[7];
      end
      if (sck_rise)
      begin
        rsh_q <= {rsh_q[6:0], lvl_q[0]};
        bit_q <= bit_q + 1'b1;
        if (bit_q == SBL_SPI_LAST)
        begin
          rx_o  <= '{valid: 1'b1, data: {rsh_q[6:0], lvl_q[0]}};
          tsh_q <= next_tx;
        end
        else
          tsh_q <= {tsh_q[6:0], 1'b0};
      end
      if (sck_fall)
        miso_o <= tsh_q[7];
    end
  end

endmodule
`default_nettype wire

// ### test/sbl_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port-level checks of the loader core
// ----------------------------------------
module sbl_core_assertions (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // Watched ports
  input  wire logic              uart_tx_o,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_miso_oe_n_o,
  input  wire sbl_pkg::sbl_cmd_t cmd_o,
  input  wire logic              cmd_valid_o,
  input  wire logic              status_we_i,
  input  wire logic [7:0]        status_i,
  input  wire logic [7:0]        status_o,
  input  wire logic              lock_uart_o,
  input  wire logic              lock_spi_o
);
  import sbl_pkg::*;

  // One clock domain; reset masks every check
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  AST_LOCK_ONE: assert property (!(lock_uart_o && lock_spi_o))
    else $error("both ports locked");
  AST_LOCK_HOLD: assert property (lock_uart_o || lock_spi_o |=> $stable({lock_uart_o, lock_spi_o}))
    else $error("port lock changed");
  AST_UART_QUIET: assert property (!lock_uart_o |-> uart_tx_o)
    else $error("uart sent while not locked");
  AST_SYNC_ACK: assert property ($rose(lock_uart_o) |-> ##[0:4] !uart_tx_o)
    else $error("no ack start bit after sync");
  AST_MISO_OFF: assert property ($past(lock_uart_o) && lock_uart_o |-> spi_miso_oe_n_o)
    else $error("miso driven while uart locked");
  AST_MISO_CS: assert property (spi_cs_n_i [*6] |-> spi_miso_oe_n_o)
    else $error("miso driven without select");
  AST_CMD_PULSE: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse too long");
  AST_CMD_CODE: assert property (cmd_valid_o |-> cmd_o.code != SBL_CMD_PING && cmd_o.code != SBL_CMD_STAT)
    else $error("ping or query handed off");
  AST_STAT_WR: assert property (status_we_i |=> status_o == $past(status_i) || status_o == SBL_ST_SUCCESS)
    else $error("status write lost");
  AST_STAT_SRC: assert property (!$stable(status_o) && !$past(status_we_i) |-> status_o == SBL_ST_SUCCESS)
    else $error("status changed without cause");
endmodule

bind sbl_core sbl_core_assertions u_chk (
  .sys_clk_i (sys_clk_i), .reset_i (reset_i), .uart_tx_o (uart_tx_o), .spi_cs_n_i (spi_cs_n_i),
  .spi_miso_oe_n_o (spi_miso_oe_n_o), .cmd_o (cmd_o), .cmd_valid_o (cmd_valid_o),
  .status_we_i (status_we_i), .status_i (status_i), .status_o (status_o),
  .lock_uart_o (lock_uart_o), .lock_spi_o (lock_spi_o)
);
`default_nettype wire

// ### test/sbl_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host model: master on both serial ports
// ----------------------------------------
module sbl_host (
  // Clock
  input  wire logic clk_i,
  // Device outputs
  input  wire logic tx_line_i,
  input  wire logic miso_i,
  // Host drives
  output var  logic rx_line_o,
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic mosi_o
);
  localparam int BIT  = 32;  // Baud at clock over 32
  localparam int HALF = 8;   // Period 16, below 1/12 of clock

  // Idle lines: serial high, clock parked high
  initial
  begin
    rx_line_o = 1'b1;
    sclk_o    = 1'b1;
    cs_n_o    = 1'b1;
    mosi_o    = 1'b0;
  end

  // Start, 8 bits LSB first, one stop
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_line_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask

  // One frame in; ok low on timeout or bad stop bit
  task automatic uart_recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (tx_line_i && n < 20000)
    begin
      @(posedge clk_i);
      n++;
    end
    ok = n < 20000;
    if (!ok)
      return;
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge clk_i);
      if (i < 8)
        b[i] = tx_line_i;
    end
    ok = tx_line_i === 1'b1;
  endtask

  // Select is held over a whole session
  task automatic spi_sel(input logic v);
    cs_n_o <= v;
    repeat (HALF) @(posedge clk_i);
  endtask

  // Drive on fall, sample on rise, MSB first
  task automatic spi_xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_o <= 1'b0;
      mosi_o <= b[i];
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (HALF / 2) @(posedge clk_i);
      mosi_o <= ~b[i];  // No stale bit left behind
      repeat (HALF / 2) @(posedge clk_i);
      r[i] = miso_i;
    end
  endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sbl_pkg::*;
  // ----------------------------------------
  // Clock, reset and wiring
  // ----------------------------------------
  logic       sys_clk_i = 1'b0;
  logic       reset_i   = 1'b1;
  logic       use_uart  = 1'b0;
  logic [7:0] rnd       = 8'h2F;
  logic [3:0] param_idx = 4'h0;
  logic       status_we = 1'b0;
  logic [7:0] status_in = 8'h00;
  logic       rx_w, tx_w, sclk_w, cs_n_w, mosi_w, miso_o, miso_oe_n, miso_w;
  sbl_cmd_t   cmd, cmd_seen;
  logic       cmd_valid, lock_uart, lock_spi;
  logic [7:0] param, status;
  int         n_fail = 0;
  int         checks = 0;
  int         cmd_hits = 0;

  // Pull-up while the device lets go
  assign miso_w = miso_oe_n ? 1'b1 : miso_o;
  always #10 sys_clk_i = ~sys_clk_i;

  sbl_core u_dut (
    .sys_clk_i (sys_clk_i), .reset_i (reset_i), .uart_rx_i (rx_w), .uart_tx_o (tx_w),
    .spi_sclk_i (sclk_w), .spi_cs_n_i (cs_n_w), .spi_mosi_i (mosi_w), .spi_miso_o (miso_o),
    .spi_miso_oe_n_o (miso_oe_n), .cmd_o (cmd), .cmd_valid_o (cmd_valid), .param_idx_i (param_idx),
    .param_o (param), .status_we_i (status_we), .status_i (status_in), .status_o (status),
    .lock_uart_o (lock_uart), .lock_spi_o (lock_spi)
  );
  sbl_host u_host (
    .clk_i (sys_clk_i), .tx_line_i (tx_w), .miso_i (miso_w), .rx_line_o (rx_w),
    .sclk_o (sclk_w), .cs_n_o (cs_n_w), .mosi_o (mosi_w)
  );

  // Catch the one-cycle command pulse
  always @(posedge sys_clk_i)
    if (cmd_valid === 1'b1)
    begin
      cmd_seen <= cmd;
      cmd_hits <= cmd_hits + 1;
    end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] sum8(input logic [7:0] d[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (d[i]) s += d[i];
    return s;
  endfunction

  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask

  // One byte out, after a random gap; a zero gap makes a burst
  task automatic put(input logic [7:0] b);
    logic [7:0] r;
    rnd = lfsr(rnd);
    repeat (rnd[1:0] * 8) @(posedge sys_clk_i);
    if (use_uart)
      u_host.uart_send(b);
    else
      u_host.spi_xfer(b, r);
  endtask

  // Poll for the first non-zero byte; filler is skipped
  task automatic get(output logic [7:0] b);
    logic ok;
    int   n;
    b = 8'h00;
    ok = 1'b1;
    n = 0;
    while (b === 8'h00 && ok && n < 8)
    begin
      if (use_uart)
        u_host.uart_recv(b, ok);
      else
        u_host.spi_xfer(8'h00, b);
      n++;
    end
    if (b === 8'h00 || !ok)
    begin
      n_fail++;
      $display("[FAIL] reply exp nonzero got %h", b);
      test_done();
    end
  endtask

  // Whole packet out, reply compared
  task automatic pkt(input logic [7:0] d[$], input logic [7:0] skew, input logic [7:0] exp, input string what);
    logic [7:0] r;
    put(8'(d.size() + 2));
    put(sum8(d) + skew);
    foreach (d[i]) put(d[i]);
    get(r);
    cmp8(what, exp, r);
    repeat (64) @(posedge sys_clk_i);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] d[$];
    logic [7:0] r, st;
    int         hits;
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cmp8("status reset", SBL_ST_RST, status);
    u_host.spi_sel(1'b0);
    d = {SBL_CMD_PING};
    pkt(d, 8'h00, SBL_ACK, "ping reply");
    cmp8("ping status", SBL_ST_SUCCESS, status);
    d = {8'h41, 8'h00};
    pkt(d, 8'h01, SBL_NAK, "bad sum reply");
    cmp8("no pulse", 8'h00, 8'(cmd_hits));
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      d = {{2'b01, rnd[5:0]}};
      repeat (k)
      begin
        rnd = lfsr(rnd);
        d.push_back(rnd & {8{k[0]}});
      end
      hits = cmd_hits;
      pkt(d, 8'h00, SBL_ACK, "cmd reply");
      cmp8("cmd pulses", 8'(hits + 1), 8'(cmd_hits));
      cmp8("cmd code", d[0], cmd_seen.code);
      cmp8("cmd count", 8'(k), cmd_seen.count);
      foreach (d[i])
      begin
        param_idx <= 4'(i);
        repeat (2) @(posedge sys_clk_i);
        cmp8("param", d[i], param);
      end
    end
    rnd = lfsr(rnd);
    st = rnd | 8'h01;
    status_we <= 1'b1;
    status_in <= st;
    @(posedge sys_clk_i);
    status_we <= 1'b0;
    d = {SBL_CMD_STAT};
    pkt(d, 8'h00, SBL_ACK, "query reply");
    get(r);
    cmp8("query len", SBL_STAT_LEN, r);
    u_host.spi_xfer(8'h00, r);
    cmp8("query sum", st, r);
    u_host.spi_xfer(8'h00, r);
    cmp8("query data", st, r);
    put(8'h00);
    put(SBL_ACK);
    d = {SBL_CMD_PING};
    pkt(d, 8'h00, SBL_ACK, "ping after query");
    u_host.uart_send(SBL_SYNC);
    u_host.uart_send(SBL_SYNC);
    repeat (64) @(posedge sys_clk_i);
    cmp8("uart shut out", 8'h00, 8'(lock_uart));
    cmp8("spi lock", 8'h01, 8'(lock_spi));
    // Second session, on the asynchronous port
    reset_i <= 1'b1;
    u_host.spi_sel(1'b1);
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    use_uart = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    u_host.uart_send(SBL_SYNC);
    u_host.uart_send(8'h54);
    repeat (1280) @(posedge sys_clk_i);
    cmp8("no sync", 8'h00, 8'(lock_uart));
    u_host.uart_send(SBL_SYNC);
    u_host.uart_send(SBL_SYNC);
    get(r);
    cmp8("sync ack", SBL_ACK, r);
    cmp8("uart lock", 8'h01, 8'(lock_uart));
    d = {SBL_CMD_PING};
    pkt(d, 8'h00, SBL_ACK, "uart ping");
    put(8'h01);
    get(r);
    cmp8("short len", SBL_NAK, r);
    u_host.spi_sel(1'b0);
    u_host.spi_xfer(SBL_SYNC, r);
    u_host.spi_sel(1'b1);
    cmp8("spi shut out", 8'h00, 8'(lock_spi));
    d = {8'h5A, 8'h00, 8'hFF};
    pkt(d, 8'h00, SBL_ACK, "uart cmd");
    cmp8("uart cmd code", 8'h5A, cmd_seen.code);
    test_done();
  end
endmodule
`default_nettype wire
